// *** eds_params.svh ***
/*
 Constants for the extended data space page translator: widths, the low
 always-reachable range, page register reset value and the zero page code.
 Assumes it is included by the package and the design modules only.
*/
`ifndef EDS_PARAMS_SVH
`define EDS_PARAMS_SVH

// widths of base address, page number and in-page offset
`define BASE_W 16
`define PAGE_W 10
`define OFS_W 15
`define EXT_W 25

// field position of the base address msb that selects the paged half
`define BASE_MSB_POS 15

// low range that is always reachable through page 0
`define LOW_FIRST 16'h0000
`define LOW_LAST 16'h2fff

// page register values
`define PAGE_RESET 10'h001
`define PAGE_ZERO 10'h000

`endif

// *** eds_pkg.sv ***
/*
 Types shared by the page translator and its page register holder.
 Assumes eds_params.svh is on the include path.
*/
`include "eds_params.svh"

package eds_pkg;

	typedef logic [`BASE_W-1:0] base_addr_t;
	typedef logic [`PAGE_W-1:0] page_t;
	typedef logic [`OFS_W-1:0] offset_t;
	typedef logic [`EXT_W-1:0] ext_addr_t;

	// how an access is routed, one-hot
	typedef enum logic [2:0] {
		KIND_IDLE = 3'b001,
		KIND_LOW = 3'b010,
		KIND_PAGED = 3'b100
	} acc_kind_t;

endpackage

// *** page_hold.sv ***
/*
 One data page register: resets to page one and refuses a load of zero.
 Assumes the load strobe and data are synchronous to clk.
*/
`include "eds_params.svh"

module page_hold
	import eds_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire page_t load_data,
	output page_t page_r
);

	page_t page_nxt;
	logic load_ok;

	// a zero load is dropped, the old page stays
	// ignore zero clear
	assign load_ok = load && (load_data != `PAGE_ZERO);
	assign page_nxt = load_ok ? load_data : page_r;

	// page register, page one after reset
	// reset to one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			page_r <= `PAGE_RESET;
		end else begin
			page_r <= page_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	zero_load_ignored_a: assert property (load && load_data == `PAGE_ZERO |=> page_r == $past(page_r))
		else $error("page register took a zero load");

	page_load_taken_a: assert property (load && load_data != `PAGE_ZERO |=> page_r == $past(load_data))
		else $error("page register missed a nonzero load");

endmodule

// *** eds_translate.sv ***
/*
 Extended data space translator: turns a 16-bit base address plus the
 read or write page register into an extended address, or an address
 error trap request. Result appears one clock after the access.
 Assumes the load/store unit presents one access per cycle on acc_valid
 and that page loads come from the core's register write path.
*/
// Behaviour
// - base addresses 0x0000 to 0x2fff are reachable whatever the page registers hold.
// - with the base msb at 0 the access is page 0, landing at 0x000000 to 0x002fff for the low range.
// - page 0 is never reached through the upper base half 0x8000 to 0xffff.
// - reset loads both the read and write page registers with one.
// - an upper-half access while the chosen page register is zero raises an address error trap.
// - a software load of zero into a page register is ignored.
// - every page except 0 is reached only by a base address with msb 1 plus a page value.
// - page N maps the upper base half onto the 32 Kbyte window starting at N times 0x8000.
`include "eds_params.svh"

module eds_translate
	import eds_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire base_addr_t base_addr,
	input wire logic read_page_load,
	input wire logic write_page_load,
	input wire page_t page_load_data,
	output logic ext_valid_r,
	output logic ext_write_r,
	output logic ext_paged_r,
	output ext_addr_t ext_addr_r,
	output logic addr_error_r,
	output page_t data_read_page_reg,
	output page_t data_write_page_reg
);

	page_t page_q [2];
	logic [1:0] page_load;
	logic base_addr_msb;
	page_t sel_page;
	offset_t offset;
	acc_kind_t kind;
	logic page_bad;
	ext_addr_t ext_addr_nxt;
	logic ext_valid_nxt;
	logic addr_error_nxt;
	logic ext_paged_nxt;

	assign page_load[0] = read_page_load;
	assign page_load[1] = write_page_load;

	// index 0 is the read page, index 1 the write page
	generate
		for (genvar i = 0; i < 2; i++) begin : g_page
			page_hold u_page (
				.clk(clk),
				.rstn(rstn),
				.load(page_load[i]),
				.load_data(page_load_data),
				.page_r(page_q[i])
			);
		end
	endgenerate

	// classify the access by the base msb
	// paged only with msb
	assign base_addr_msb = base_addr[`BASE_MSB_POS];
	assign kind = !acc_valid ? KIND_IDLE : (base_addr_msb ? KIND_PAGED : KIND_LOW);

	assign sel_page = acc_write ? page_q[1] : page_q[0];
	assign offset = base_addr[`OFS_W-1:0];

	assign page_bad = (sel_page == `PAGE_ZERO);

	// address and status for the next cycle
	always_comb begin
		ext_addr_nxt = '0;
		ext_valid_nxt = 1'b0;
		addr_error_nxt = 1'b0;
		ext_paged_nxt = 1'b0;
		unique case (kind)
			KIND_IDLE: begin
				ext_addr_nxt = '0;
			end
			KIND_LOW: begin
				ext_addr_nxt = {`PAGE_ZERO, offset};
				ext_valid_nxt = 1'b1;
			end
			KIND_PAGED: begin
				ext_addr_nxt = {sel_page, offset};
				ext_valid_nxt = !page_bad;
				addr_error_nxt = page_bad;
				ext_paged_nxt = 1'b1;
			end
			default: begin
				ext_addr_nxt = '0;
			end
		endcase
	end

	// registered result, one cycle after the access
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ext_valid_r <= 1'b0;
			ext_write_r <= 1'b0;
			ext_paged_r <= 1'b0;
			ext_addr_r <= '0;
			addr_error_r <= 1'b0;
		end else begin
			ext_valid_r <= ext_valid_nxt;
			ext_write_r <= acc_valid && acc_write;
			ext_paged_r <= ext_paged_nxt;
			ext_addr_r <= ext_addr_nxt;
			addr_error_r <= addr_error_nxt;
		end
	end

	// page registers shown to the core, registered copies
	always_ff @(posedge clk) begin
		if (!rstn) begin
			data_read_page_reg <= `PAGE_RESET;
			data_write_page_reg <= `PAGE_RESET;
		end else begin
			data_read_page_reg <= page_q[0];
			data_write_page_reg <= page_q[1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence low_access_s;
		acc_valid && base_addr <= `LOW_LAST;
	endsequence

	low_always_reach_a: assert property (low_access_s |=> ext_valid_r && !addr_error_r)
		else $error("low range access did not complete");

	low_page_zero_a: assert property (
		acc_valid && !base_addr[`BASE_MSB_POS]
		|=> ext_addr_r == {`PAGE_ZERO, $past(base_addr[`OFS_W-1:0])} && !ext_paged_r)
		else $error("msb-clear access not mapped to page zero");

	no_page_zero_a: assert property (ext_valid_r && ext_paged_r |-> ext_addr_r[`EXT_W-1:`OFS_W] != `PAGE_ZERO)
		else $error("upper half reached page zero");

	// watches reset itself, so the default disable must not apply here
	reset_page_one_a: assert property (
		@(posedge clk) disable iff (1'b0)
		!rstn |=> page_q[0] == `PAGE_RESET && page_q[1] == `PAGE_RESET ##1
		data_read_page_reg == `PAGE_RESET && data_write_page_reg == `PAGE_RESET)
		else $error("page registers not one after reset");

	// copies trail the page registers by one clock, skipped on the edge after reset
	page_copy_lag_a: assert property (
		$past(rstn) |-> data_read_page_reg == $past(page_q[0]) && data_write_page_reg == $past(page_q[1]))
		else $error("page copy does not follow its register");

	zero_page_trap_a: assert property (
		acc_valid && base_addr_msb && sel_page == `PAGE_ZERO |=> addr_error_r && !ext_valid_r)
		else $error("zero page access did not trap");

	trap_only_paged_a: assert property (addr_error_r |-> ext_paged_r && $past(acc_valid))
		else $error("trap without a paged access");

	// every access gets exactly one answer, completion or trap
	one_answer_a: assert property (acc_valid |=> ext_valid_r != addr_error_r)
		else $error("access without exactly one answer");

	zero_load_kept_a: assert property (
		read_page_load && page_load_data == `PAGE_ZERO && !write_page_load
		|=> page_q[0] == $past(page_q[0]))
		else $error("read page cleared to zero");

	write_zero_kept_a: assert property (
		write_page_load && page_load_data == `PAGE_ZERO
		|=> page_q[1] == $past(page_q[1]))
		else $error("write page cleared to zero");

	high_pages_paged_a: assert property (
		ext_valid_r && ext_addr_r[`EXT_W-1:`OFS_W] != `PAGE_ZERO |-> ext_paged_r)
		else $error("nonzero page reached without msb");

	// paged flag follows the base msb of the access
	paged_flag_a: assert property (acc_valid |=> ext_paged_r == $past(base_addr_msb))
		else $error("paged flag does not follow the base msb");

	read_window_a: assert property (
		acc_valid && base_addr_msb && !acc_write && page_q[0] != `PAGE_ZERO
		|=> ext_addr_r == {$past(page_q[0]), $past(base_addr[`OFS_W-1:0])} && ext_valid_r)
		else $error("read page window wrong");

	write_window_a: assert property (
		acc_valid && base_addr_msb && acc_write
		|=> ext_write_r && ext_addr_r[`EXT_W-1:`OFS_W] == $past(page_q[1]))
		else $error("write used the wrong page");

	read_page_used_a: assert property (
		acc_valid && base_addr_msb && !acc_write
		|=> !ext_write_r && ext_addr_r[`EXT_W-1:`OFS_W] == $past(page_q[0]))
		else $error("read used the wrong page");

	write_flag_a: assert property (acc_valid |=> ext_write_r == $past(acc_write))
		else $error("write flag does not follow the access");

	// a cycle without an access leaves every result low and the address at zero
	idle_quiet_a: assert property (
		!acc_valid
		|=> !ext_valid_r && !addr_error_r && !ext_write_r && !ext_paged_r && ext_addr_r == '0)
		else $error("result shown for an idle cycle");

	// main scenarios
	low_access_c: cover property (low_access_s ##1 ext_valid_r);
	paged_read_c: cover property (acc_valid && base_addr_msb && !acc_write && page_q[0] != `PAGE_RESET);
	paged_write_c: cover property (acc_valid && base_addr_msb && acc_write ##1 ext_valid_r);
	zero_load_c: cover property (write_page_load && page_load_data == `PAGE_ZERO);
	dual_load_c: cover property (read_page_load && write_page_load && page_load_data != `PAGE_ZERO);

endmodule

// *** lsu_model.sv ***
/*
 Stand-in for the core's load/store address unit: presents accesses.
 Assumes calls are made just after a falling clock edge.
*/
module lsu_model
	import eds_pkg::*;
(
	input wire logic clk,
	output logic acc_valid,
	output logic acc_write,
	output base_addr_t base_addr
);
	timeunit 1ns;
	timeprecision 1ns;

	// quiet bus at time zero
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		base_addr = 16'h0000;
	end

	// hold one access across a rising edge
	task automatic issue(input logic wr, input base_addr_t a);
		acc_valid = 1'b1;
		acc_write = wr;
		base_addr = a;
		@(negedge clk);
	endtask

	// release: the address flips so stale values never look valid
	task automatic idle();
		acc_valid = 1'b0;
		base_addr = ~base_addr;
		@(negedge clk);
	endtask
endmodule

// *** extended_data_space_paging_tb.sv ***
/*
 Self-checking bench for the page translator.
 Assumes inputs change on the falling edge and results land one edge later.
*/
module extended_data_space_paging_tb
	import eds_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rpl = 1'b0;
	logic wpl = 1'b0;
	page_t pdata = 10'h000;
	logic acc_valid;
	logic acc_write;
	base_addr_t base_addr;
	logic ev;
	logic ew;
	logic ep;
	logic ae;
	ext_addr_t ea;
	page_t rd_pg;
	page_t wr_pg;
	int err_total = 0;
	int tests_run = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	lsu_model agu (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write), .base_addr(base_addr));

	eds_translate dut (.clk(clk), .rstn(rstn), .acc_valid(acc_valid), .acc_write(acc_write),
		.base_addr(base_addr), .read_page_load(rpl), .write_page_load(wpl), .page_load_data(pdata),
		.ext_valid_r(ev), .ext_write_r(ew), .ext_paged_r(ep), .ext_addr_r(ea), .addr_error_r(ae),
		.data_read_page_reg(rd_pg), .data_write_page_reg(wr_pg));

	// compare address or page values
	task automatic chk_val(input ext_addr_t got, input ext_addr_t exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// compare valid, write, paged and trap flags
	task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one access, then judge its result
	task automatic do_acc(input logic wr, input base_addr_t a, input logic pg, input ext_addr_t exp);
		agu.issue(wr, a);
		chk_flag({ev, ew, ep, ae}, {1'b1, wr, pg, 1'b0});
		chk_val(ea, exp);
	endtask

	// page copies right after reset
	task automatic t_reset();
		chk_val(ext_addr_t'(rd_pg), 25'h0000001);
		chk_val(ext_addr_t'(wr_pg), 25'h0000001);
	endtask

	// low half lands in page 0, back to back
	task automatic t_low();
		do_acc(1'b0, 16'h2fff, 1'b0, 25'h0002fff);
		do_acc(1'b1, 16'h0000, 1'b0, 25'h0000000);
		do_acc(1'b0, 16'h7fff, 1'b0, 25'h0007fff);
		agu.idle();
		chk_flag({ev, ew, ep, ae}, 4'h0);
	endtask

	// upper half through the reset page
	task automatic t_page1();
		do_acc(1'b0, 16'h8004, 1'b1, 25'h0008004);
		do_acc(1'b1, 16'hffff, 1'b1, 25'h000ffff);
		agu.idle();
	endtask

	// write page to 2, zero into read page is dropped
	task automatic t_loads();
		wpl = 1'b1;
		pdata = 10'h002;
		@(negedge clk);
		wpl = 1'b0;
		rpl = 1'b1;
		pdata = 10'h000;
		@(negedge clk);
		rpl = 1'b0;
		do_acc(1'b1, 16'hffff, 1'b1, 25'h0017fff);
		do_acc(1'b0, 16'h8000, 1'b1, 25'h0008000);
		agu.idle();
		chk_val(ext_addr_t'(rd_pg), 25'h0000001);
		chk_val(ext_addr_t'(wr_pg), 25'h0000002);
	endtask

	// both pages to 3 in one cycle, zero into both dropped, then a reset in mid-run
	task automatic t_mid_reset();
		rpl = 1'b1;
		wpl = 1'b1;
		pdata = 10'h003;
		@(negedge clk);
		pdata = 10'h000;
		@(negedge clk);
		rpl = 1'b0;
		wpl = 1'b0;
		do_acc(1'b0, 16'hc123, 1'b1, 25'h001c123);
		do_acc(1'b1, 16'h8001, 1'b1, 25'h0018001);
		agu.idle();
		chk_val(ext_addr_t'(rd_pg), 25'h0000003);
		chk_val(ext_addr_t'(wr_pg), 25'h0000003);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		chk_val(ext_addr_t'(rd_pg), 25'h0000001);
		chk_val(ext_addr_t'(wr_pg), 25'h0000001);
		do_acc(1'b0, 16'hc123, 1'b1, 25'h000c123);
		agu.idle();
	endtask

	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_reset();
		t_low();
		t_page1();
		t_loads();
		t_mid_reset();
		wrap_up();
	end

	// watchdog, far beyond the few dozen cycles needed
	initial begin
		#40000;
		err_total++;
		wrap_up();
	end
endmodule
